// >>> include/swg_pkg.sv
// Constants and helpers shared by the write guard and identification block
package swg_pkg;
  // Fixed opcodes
  localparam logic [7:0] OPC_JEDEC_ID  = 8'h9f;
  localparam logic [7:0] OPC_LEGACY_A  = 8'h90;
  localparam logic [7:0] OPC_LEGACY_B  = 8'hab;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  // Defaults for the configurable opcodes
  localparam logic [7:0] OPC_SET_DFLT  = 8'h06;
  localparam logic [7:0] OPC_ARM_DFLT  = 8'h50;
  localparam logic [7:0] OPC_SW_DFLT   = 8'h01;
  // Identity codes, values arbitrary
  localparam logic [7:0] MFR_DFLT      = 8'h5a;
  localparam logic [7:0] TYPE_DFLT     = 8'h3c;
  localparam logic [7:0] CAP_DFLT      = 8'h17;
  // Bit counts seen on the link, saturating
  localparam logic [5:0] CNT_MAX       = 6'h3f;
  localparam logic [5:0] OPC_BITS      = 6'h08;
  localparam logic [5:0] SW_BITS       = 6'h10;
  localparam logic [5:0] LEG_BITS      = 6'h20;
  // Status byte layout and values after reset
  localparam int         SR_PROT_LO    = 2;
  localparam int         SR_LOCK       = 7;
  localparam logic [3:0] BP_RST        = 4'hf;
  localparam logic       LOCK_RST      = 1'b0;

  function automatic logic cmd_hit(input logic [7:0] op,
                                   input logic [7:0] want,
                                   input logic [5:0] cnt,
                                   input logic [5:0] len,
                                   input logic       at_least);
    cmd_hit = (op == want) && (at_least ? (cnt >= len) : (cnt == len));
  endfunction

  function automatic logic is_legacy(input logic [7:0] op);
    is_legacy = (op == OPC_LEGACY_A) || (op == OPC_LEGACY_B);
  endfunction
endpackage

// >>> logic/swg_link.sv
// Serial link end: shifts commands in and identification bytes out on sclk
`timescale 1ns/1ps
module swg_link import swg_pkg::*; #(
  parameter logic [7:0] MFR_CODE = MFR_DFLT,
  parameter logic [7:0] MEM_TYPE = TYPE_DFLT,
  parameter logic [7:0] CAP_CODE = CAP_DFLT
) (
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       nrst,
  input  wire logic       si,
  output logic      [7:0] rx_cmd,
  output logic      [7:0] rx_dat,
  output logic      [5:0] rx_cnt,
  output logic            so_out,
  output logic            so_oe
);
  logic        tx_clr;
  logic        live_ff;
  logic [6:0]  sh_ff;
  logic [5:0]  cnt_ff;
  logic [5:0]  nxt_cnt;
  logic [7:0]  nxt_byte;
  logic [7:0]  cmd_ff;
  logic [7:0]  dat_ff;
  logic        a0_ff;
  logic        so_ff;
  logic        oe_ff;
  logic        rot_ff;
  logic [23:0] osh_ff;
  logic [15:0] pair;
  logic        start_id;
  logic        start_leg;

  // Frame end clears the output side at once, since sclk may already be still
  assign tx_clr = cs_n | ~nrst;

  always_ff @(posedge sclk or posedge tx_clr) begin
    if (tx_clr)
      live_ff <= 1'b0;
    else
      live_ff <= 1'b1;
  end

  always_comb begin
    nxt_byte = {sh_ff, si};
    if (!live_ff)
      nxt_cnt = 6'h01;
    else if (cnt_ff == CNT_MAX)
      nxt_cnt = CNT_MAX;
    else
      nxt_cnt = cnt_ff + 6'h01;
  end

  // Captured bytes hold after the frame so the core can read them at leisure
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      sh_ff  <= '0;
      cnt_ff <= '0;
      cmd_ff <= '0;
      dat_ff <= '0;
      a0_ff  <= 1'b0;
    end else begin
      sh_ff  <= nxt_byte[6:0];
      cnt_ff <= nxt_cnt;
      if (nxt_cnt == OPC_BITS)
        cmd_ff <= nxt_byte;
      if (nxt_cnt == SW_BITS)
        dat_ff <= nxt_byte;
      if (nxt_cnt == LEG_BITS)
        a0_ff <= si;
    end
  end

  assign start_id  = live_ff && cnt_ff == OPC_BITS && cmd_ff == OPC_JEDEC_ID;
  assign start_leg = live_ff && cnt_ff == LEG_BITS && is_legacy(cmd_ff);
  assign pair      = a0_ff ? {CAP_CODE, MFR_CODE} : {MFR_CODE, CAP_CODE};

  always_ff @(negedge sclk or posedge tx_clr) begin
    if (tx_clr) begin
      so_ff  <= 1'b0;
      oe_ff  <= 1'b0;
      rot_ff <= 1'b0;
      osh_ff <= '0;
    end else if (!oe_ff) begin
      if (start_id) begin
        oe_ff  <= 1'b1;
        so_ff  <= MFR_CODE[7];
        osh_ff <= {MFR_CODE[6:0], MEM_TYPE, CAP_CODE, 1'b0};
      end else if (start_leg) begin
        oe_ff  <= 1'b1;
        rot_ff <= 1'b1;
        so_ff  <= pair[15];
        osh_ff <= {8'h00, pair[14:0], pair[15]};
      end
    end else if (rot_ff) begin
      so_ff  <= osh_ff[15];
      osh_ff <= {8'h00, osh_ff[14:0], osh_ff[15]};
    end else begin
      so_ff  <= osh_ff[23];
      osh_ff <= {osh_ff[22:0], 1'b0};
    end
  end

  assign rx_cmd = cmd_ff;
  assign rx_dat = dat_ff;
  assign rx_cnt = cnt_ff;
  assign so_out = so_ff;
  assign so_oe  = oe_ff;

  a_id_first_bit: assert property (@(negedge sclk) disable iff (cs_n)
    $rose(oe_ff) && !rot_ff |-> so_ff == MFR_CODE[7])
    else $error("identification read did not open with manufacturer msb");
  a_legacy_period: assert property (@(negedge sclk) disable iff (cs_n)
    $rose(oe_ff) && rot_ff |-> ##16 so_ff == $past(so_ff, 16))
    else $error("legacy identification output did not repeat every two bytes");
  c_jedec_out: cover property (@(negedge sclk) disable iff (cs_n)
    $rose(oe_ff) && !rot_ff);
  c_legacy_out: cover property (@(negedge sclk) disable iff (cs_n)
    $rose(oe_ff) && rot_ff);
endmodule

// >>> logic/swg_top.sv
// Write permission and identification command logic of a serial flash
//
// How it works
// - Set-write-latch command sets the write latch to 1.
// - A status write clears the write latch when its frame ends.
// - Latch and arm commands take effect only at chip-select rise.
// - Clear-write-latch command clears write latch and auto-increment flag.
// - Clear-write-latch never aborts a program already running.
// - Arming opens the status write for the very next command only.
// - Status write changes only four protect bits and lock bit, at frame end.
// - Status write ignored while protect pin low and lock bit set.
// - With protect pin low, lock bit may go 0 to 1 only.
// - Protect pin high disables lock-down; all protect bits writable.
// - Lock judged at frame end; one write may set lock and protect bits.
// - Opcode 9f returns manufacturer, memory type and capacity bytes.
// - Chip-select rise stops identification output at any point.
// - Legacy identification uses opcode 90 or ab plus 24 address bits.
// - Legacy address 0 gives manufacturer code, address 1 device code.
// - Legacy output alternates the two codes until chip select rises.
// - Clear-write-latch opcode is 04.
`timescale 1ns/1ps
module swg_top import swg_pkg::*; #(
  parameter logic [7:0] SET_LATCH_OPC = OPC_SET_DFLT,
  parameter logic [7:0] ARM_SW_OPC    = OPC_ARM_DFLT,
  parameter logic [7:0] STATUS_WR_OPC = OPC_SW_DFLT,
  parameter logic [7:0] MFR_CODE      = MFR_DFLT,
  parameter logic [7:0] MEM_TYPE      = TYPE_DFLT,
  parameter logic [7:0] CAP_CODE      = CAP_DFLT
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  input  wire logic autoinc_start,
  output logic      so_out,
  output logic      so_oe,
  output logic      write_latch,
  output logic      auto_increment_program_flag,
  output logic      block_protect_bit0,
  output logic      block_protect_bit1,
  output logic      block_protect_bit2,
  output logic      block_protect_bit3,
  output logic      protect_lock_bit,
  output logic      status_armed
);
  logic [1:0] cs_sync_ff;
  logic       cs_dly_ff;
  logic [1:0] wp_sync_ff;
  logic       cs_rise;
  logic       wp_high;
  logic [7:0] rx_cmd;
  logic [7:0] rx_dat;
  logic [5:0] rx_cnt;
  logic       set_hit;
  logic       clr_hit;
  logic       arm_hit;
  logic       sw_hit;
  logic       sw_en;
  logic       locked;
  logic       sw_take;
  logic [3:0] new_bp;
  logic       new_lock;
  logic       wel_ff;
  logic       autoinc_ff;
  logic       armed_ff;
  logic [3:0] bp_ff;
  logic       lock_ff;

  swg_link #(
    .MFR_CODE (MFR_CODE),
    .MEM_TYPE (MEM_TYPE),
    .CAP_CODE (CAP_CODE)
  ) u_link (
    .sclk   (sclk),
    .cs_n   (cs_n),
    .nrst   (nrst),
    .si     (si),
    .rx_cmd (rx_cmd),
    .rx_dat (rx_dat),
    .rx_cnt (rx_cnt),
    .so_out (so_out),
    .so_oe  (so_oe)
  );

  // Chip select and protect pin cross in by two flops each
  always_ff @(posedge core_clk) begin
    if (!nrst)
      cs_sync_ff <= 2'b11;
    else
      cs_sync_ff <= {cs_sync_ff[0], cs_n};
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      cs_dly_ff <= 1'b1;
    else
      cs_dly_ff <= cs_sync_ff[1];
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      wp_sync_ff <= 2'b00;
    else
      wp_sync_ff <= {wp_sync_ff[0], wp_n};
  end

  // Link bytes are read only after the synced rise: sclk is then still,
  // so they stand steady. Limitation: a new frame must not clock its
  // first bit within about three core cycles of the previous rise.
  assign cs_rise = cs_sync_ff[1] & ~cs_dly_ff;
  assign wp_high = wp_sync_ff[1];

  always_comb begin
    set_hit = cs_rise && cmd_hit(rx_cmd, SET_LATCH_OPC, rx_cnt, OPC_BITS, 1'b0);
    clr_hit = cs_rise && cmd_hit(rx_cmd, OPC_CLR_LATCH, rx_cnt, OPC_BITS, 1'b0);
    arm_hit = cs_rise && cmd_hit(rx_cmd, ARM_SW_OPC, rx_cnt, OPC_BITS, 1'b0);
    sw_hit  = cs_rise && cmd_hit(rx_cmd, STATUS_WR_OPC, rx_cnt, SW_BITS, 1'b1);
  end

  assign new_bp   = rx_dat[SR_PROT_LO +: 4];
  assign new_lock = rx_dat[SR_LOCK];
  assign sw_en    = armed_ff | wel_ff;
  assign locked   = ~wp_high & lock_ff;
  assign sw_take = sw_hit & sw_en & ~locked;

  // The latch gates program and erase elsewhere; it is only a permission
  always_ff @(posedge core_clk) begin
    if (!nrst)
      wel_ff <= 1'b0;
    else if (set_hit)
      wel_ff <= 1'b1;
    else if (clr_hit)
      wel_ff <= 1'b0;
    else if (sw_hit)
      wel_ff <= 1'b0;
  end

  // A set from the program path in the same cycle wins over the clear.
  // Nothing here stops a running program, which finishes on its own.
  always_ff @(posedge core_clk) begin
    if (!nrst)
      autoinc_ff <= 1'b0;
    else if (autoinc_start)
      autoinc_ff <= 1'b1;
    else if (clr_hit)
      autoinc_ff <= 1'b0;
  end

  // Any completed frame other than another arm command ends the arming, so it covers one command only
  always_ff @(posedge core_clk) begin
    if (!nrst)
      armed_ff <= 1'b0;
    else if (cs_rise)
      armed_ff <= arm_hit;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      bp_ff <= BP_RST;
    else if (sw_take)
      bp_ff <= new_bp;
  end

  // Lock can only fall while the pin is high, since with the pin low a set lock blocks the write
  always_ff @(posedge core_clk) begin
    if (!nrst)
      lock_ff <= LOCK_RST;
    else if (sw_take)
      lock_ff <= new_lock;
  end

  assign write_latch                 = wel_ff;
  assign auto_increment_program_flag = autoinc_ff;
  assign block_protect_bit0          = bp_ff[0];
  assign block_protect_bit1          = bp_ff[1];
  assign block_protect_bit2          = bp_ff[2];
  assign block_protect_bit3          = bp_ff[3];
  assign protect_lock_bit            = lock_ff;
  assign status_armed                = armed_ff;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_latch_set: assert property (
    set_hit |=> wel_ff)
    else $error("write latch not set after set-write-latch frame");

  a_latch_sw_clear: assert property (
    sw_hit |=> !wel_ff)
    else $error("write latch still set after status write frame");

  a_only_at_rise: assert property (
    !cs_rise |=> $stable(wel_ff) && $stable(armed_ff)
                 && $stable(bp_ff) && $stable(lock_ff))
    else $error("command state changed without a chip-select rise");

  a_clear_both: assert property (
    clr_hit && !autoinc_start |=> !wel_ff && !autoinc_ff)
    else $error("clear-write-latch left latch or auto-increment flag set");

  a_autoinc_set_wins: assert property (
    autoinc_start |=> autoinc_ff)
    else $error("auto-increment flag lost its set");

  a_arm_one_shot: assert property (
    cs_rise && !arm_hit |=> !armed_ff)
    else $error("arming survived a second command");

  a_arm_then_write: assert property (
    cs_rise && armed_ff && !sw_hit |=> $stable(bp_ff) && $stable(lock_ff))
    else $error("arming applied to a command that was not a status write");

  a_sw_update: assert property (
    sw_hit && sw_en && !locked |=> bp_ff == $past(new_bp) && lock_ff == $past(new_lock))
    else $error("status write did not load protect and lock bits");

  a_sw_unarmed: assert property (
    sw_hit && !sw_en |=> $stable(bp_ff) && $stable(lock_ff))
    else $error("status write changed bits without arming or latch");

  a_lock_ignore: assert property (
    sw_hit && !wp_high && lock_ff |=> $stable(bp_ff) && $stable(lock_ff))
    else $error("locked status write was not ignored");

  a_lock_sticky: assert property (
    lock_ff && !wp_high |=> lock_ff)
    else $error("lock bit fell while protect pin low");

  a_pin_high_free: assert property (
    sw_hit && wp_high && sw_en |=> lock_ff == $past(new_lock) && bp_ff == $past(new_bp))
    else $error("protect pin high did not release lock-down");

  a_out_stops: assert property (
    cs_sync_ff[1] && cs_dly_ff |-> !so_oe)
    else $error("serial output still driven after chip select rose");

  a_arm_sets: assert property (
    arm_hit |=> armed_ff)
    else $error("arm-status-write frame did not arm the status write");

  a_sw_ends_arm: assert property (
    sw_hit |=> !armed_ff)
    else $error("arming outlived the status write");

  a_latch_cause: assert property (
    $rose(wel_ff) |-> $past(set_hit))
    else $error("write latch rose without a set-write-latch frame");

  a_autoinc_cause: assert property (
    $fell(autoinc_ff) |-> $past(clr_hit))
    else $error("auto-increment flag fell without a clear frame");

  a_lock_fall_pin: assert property (
    $fell(lock_ff) |-> $past(wp_high))
    else $error("lock bit fell while protect pin low");

  a_bp_cause: assert property (
    !$stable(bp_ff) |-> $past(sw_take))
    else $error("protect bits changed without an accepted status write");

  a_lock_rise_low: assert property (
    sw_take && !wp_high && new_lock |=> lock_ff)
    else $error("unlocked status write failed to set the lock bit");

  a_refused_keeps: assert property (
    sw_hit && !sw_take |=> $stable(bp_ff) && $stable(lock_ff))
    else $error("refused status write altered protect or lock bits");

  c_lock_down: cover property (sw_take && !lock_ff && new_lock && !wp_high);
  c_lock_refused: cover property (sw_hit && locked);
  c_arm_write: cover property (arm_hit ##[1:200] sw_take);
endmodule

// >>> tb/swg_host.sv
// Host serial master model that frames commands and captures returned bits
`timescale 1ns/1ps
module swg_host (
  input  wire logic core_clk,
  input  wire logic so_out,
  input  wire logic so_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  // Half period of the link clock; raised by the bench for a slow frame
  int half = 3;

  initial begin
    sclk = 1'b0;
    si   = 1'b0;
    // Deselect only after the bench drops reset, so the link sees a clean clear edge
    #2;
    cs_n = 1'b1;
  end

  // Sclk idles low and only runs inside a frame
  task automatic xfer(input  logic [63:0] dat,
                      input  int          n,
                      input  int          hold,
                      output logic [63:0] got);
    got = '0;
    cs_n <= 1'b0;                            // Held low for the whole frame
    for (int i = 0; i < n; i++) begin
      si = dat[63-i];                        // Msb first, changed while sclk low
      #(half);
      sclk = 1'b1;
      got = {got[62:0], so_oe ? so_out : ~got[0]}; // Undriven line reads as noise
      #(half);
      sclk = 1'b0;
    end
    #(half);
    repeat (hold) @(posedge core_clk);
    cs_n <= 1'b1;                            // Rise ends the command
    si = ~si;
    // Core acts about three cycles after the rise, so wait before the next frame
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the write guard and identification block
`timescale 1ns/1ps
module testbench import swg_pkg::*; ();
  logic        core_clk;
  logic        nrst;
  logic        wp_n;
  logic        autoinc_start;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        so_out;
  logic        so_oe;
  logic        wl;
  logic        autoinc;
  logic [3:0]  bp;
  logic        lock;
  logic        armed;
  logic [7:0]  st;
  logic [63:0] got;
  int          fail_count;
  int          samples_checked;

  // Packed view: lock, armed, protect bits 3..0, auto-increment flag, write latch
  assign st = {lock, armed, bp, autoinc, wl};

  swg_top DUT (
    .core_clk                    (core_clk),
    .nrst                        (nrst),
    .sclk                        (sclk),
    .cs_n                        (cs_n),
    .si                          (si),
    .wp_n                        (wp_n),
    .autoinc_start               (autoinc_start),
    .so_out                      (so_out),
    .so_oe                       (so_oe),
    .write_latch                 (wl),
    .auto_increment_program_flag (autoinc),
    .block_protect_bit0          (bp[0]),
    .block_protect_bit1          (bp[1]),
    .block_protect_bit2          (bp[2]),
    .block_protect_bit3          (bp[3]),
    .protect_lock_bit            (lock),
    .status_armed                (armed)
  );

  swg_host host (
    .core_clk (core_clk),
    .so_out   (so_out),
    .so_oe    (so_oe),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .si       (si)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic op(input logic [7:0] c);
    host.xfer({c, 56'h0}, 8, 0, got);
  endtask

  task automatic wsr(input logic [7:0] d);
    host.xfer({OPC_SW_DFLT, d, 48'h0}, 16, 0, got);
  endtask

  task automatic set_wp(input logic v);
    @(posedge core_clk);
    wp_n <= v;
    repeat (4) @(posedge core_clk);
  endtask

  // Covers a hung handshake; the tests need well under 50 us
  initial begin
    #200us;
    fail_count++;
    finish_test();
  end

  initial begin
    // Reset falls just after time zero so its edge is not lost at start-up
    #1;
    nrst = 1'b0;
    wp_n = 1'b1;
    autoinc_start = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(st, 8'h3c);
    chk(so_oe, 1'b0);
    // Latch must not move while the frame is still open
    fork
      host.xfer({OPC_SET_DFLT, 56'h0}, 8, 10, got);
      begin
        repeat (8) @(posedge core_clk);
        chk(wl, 1'b0);
      end
    join
    chk(st, 8'h3d);
    @(posedge core_clk);
    autoinc_start <= 1'b1;
    @(posedge core_clk);
    autoinc_start <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(st, 8'h3f);
    op(OPC_CLR_LATCH);
    chk(st, 8'h3c);
    op(OPC_ARM_DFLT);
    chk(st, 8'h7c);
    wsr(8'h00);
    chk(st, 8'h00);
    // Arming is lost when another frame comes between
    op(OPC_ARM_DFLT);
    host.xfer({OPC_JEDEC_ID, 56'h0}, 32, 0, got);
    chk(got[23:0], {MFR_DFLT, TYPE_DFLT, CAP_DFLT});
    wsr(8'h3c);
    chk(st, 8'h00);
    set_wp(1'b0);
    op(OPC_SET_DFLT);
    wsr(8'hbc);
    chk(st, 8'hbc);
    op(OPC_ARM_DFLT);
    wsr(8'h00);
    chk(st, 8'hbc);
    set_wp(1'b1);
    op(OPC_ARM_DFLT);
    wsr(8'h44);
    chk(st, 8'h04);
    // Cut the identification output after four bits
    host.xfer({OPC_JEDEC_ID, 56'h0}, 12, 0, got);
    chk(got[3:0], {28'h0, MFR_DFLT[7:4]});
    chk(so_oe, 1'b0);
    // Both legacy opcodes, both address parities, last one on a slow clock
    for (int k = 0; k < 4; k++) begin
      host.half = (k == 3) ? 9 : 3;
      host.xfer({k[1] ? OPC_LEGACY_B : OPC_LEGACY_A, 23'h0, k[0], 32'h0}, 64, 0, got);
      chk(got[31:0], k[0] ? {2{CAP_DFLT, MFR_DFLT}} : {2{MFR_DFLT, CAP_DFLT}});
    end
    chk(st, 8'h04);
    finish_test();
  end
endmodule
